// ==== rtl/tcch_core.v ====
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "tcch_map.vh"
// Notes on behaviour
// - 32-bit counter, increments, readable live
// - Wrap from maximum sets overflow flag
// - Soft and external triggers act at next counting edge; C match on its own
// - Block setup routes ext clocks or chain
// - Clock select: three external, four divided, slow
// - Optional inversion and burst gating by external
// - Enable, disable, auto-disable on B load/C match
// - Disabled clock ignores start/stop; status flag
// - Triggers start clock; B load/C match stop
// - Mode bit: capture inputs, waveform drives line A, and line B unless B is the event source
// - Soft trigger, sync, block sync all channels
// - C match triggers when option set
// - Waveform external event triggers when enabled
// - A and B capture on chosen A edges
// - A loads once per trigger or after B
// - B loads only after A loaded
// - Unread reload overwrites and flags overrun
// - Capture trigger line and edge select
// - Waveform compares drive output lines
// - Shape 00 free-runs up, C no trigger
module tcch_core (
  // Clock and reset
  input wire CLOCK,
  input wire RSTN,
  // AXI4-Lite slave
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // External clock pins and chained A lines of the other channels
  input wire [2:0] EXT_CLOCK_PIN,
  input wire [1:0] CHAIN_LINE_A,
  // I/O line A
  input wire IO_LINE_A_IN,
  output reg IO_LINE_A_OUT,
  output reg IO_LINE_A_OE,
  // I/O line B
  input wire IO_LINE_B_IN,
  output reg IO_LINE_B_OUT,
  output reg IO_LINE_B_OE,
  // Block sync to the other channels
  output reg SYNC_OUT
);
  reg [31:0] channel_mode_setup;
  reg [5:0] block_routing_setup;
  reg [31:0] live_count_value;
  reg [31:0] capture_compare_a;
  reg [31:0] capture_compare_b;
  reg [31:0] compare_c;
  reg counter_wrap_flag;
  reg capture_overrun_flag;
  reg clock_enabled_flag;
  reg running;
  reg trig_pend;
  reg a_loaded;
  reg b_loaded;
  reg a_unread;
  reg b_unread;
  reg [7:0] div_cnt;
  reg [15:0] slow_cnt;
  reg slow_tick;
  reg sel_q;
  reg line_a_q;
  reg line_b_q;
  reg ev_q;
  reg have_aw;
  reg have_w;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  wire [2:0] cks = channel_mode_setup[`TCCH_M_CKS_HI:`TCCH_M_CKS_LO];
  wire [1:0] burst = channel_mode_setup[`TCCH_M_BST_HI:`TCCH_M_BST_LO];
  wire [1:0] etrg_edge = channel_mode_setup[`TCCH_M_ETE_HI:`TCCH_M_ETE_LO];
  wire [1:0] evsrc = channel_mode_setup[`TCCH_M_EVS_HI:`TCCH_M_EVS_LO];
  wire [1:0] lda = channel_mode_setup[`TCCH_M_LDA_HI:`TCCH_M_LDA_LO];
  wire [1:0] ldb = channel_mode_setup[`TCCH_M_LDB_HI:`TCCH_M_LDB_LO];
  wire [1:0] shape = channel_mode_setup[`TCCH_M_SHP_HI:`TCCH_M_SHP_LO];
  wire wave = channel_mode_setup[`TCCH_M_WAVE];
  wire b_is_event = wave && (evsrc == 2'h0);
  // Routing of external clock inputs
  reg [2:0] ext_clock_input;
  integer k;
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      ext_clock_input[k] = EXT_CLOCK_PIN[k];
    end
    if (block_routing_setup[1:0] == 2'h2) ext_clock_input[0] = CHAIN_LINE_A[0];
    if (block_routing_setup[3:2] == 2'h2) ext_clock_input[1] = CHAIN_LINE_A[1];
    if (block_routing_setup[5:4] == 2'h2) ext_clock_input[2] = CHAIN_LINE_A[0];
  end
  // Counting clock source, inversion, burst gate
  reg sel_lvl;
  reg gate;
  always @* begin
    case (cks)
      3'h0: sel_lvl = div_cnt[0];
      3'h1: sel_lvl = div_cnt[2];
      3'h2: sel_lvl = div_cnt[4];
      3'h3: sel_lvl = div_cnt[6];
      3'h4: sel_lvl = slow_tick;
      3'h5: sel_lvl = ext_clock_input[0];
      3'h6: sel_lvl = ext_clock_input[1];
      default: sel_lvl = ext_clock_input[2];
    endcase
    sel_lvl = sel_lvl ^ channel_mode_setup[`TCCH_M_INV];
    case (burst)
      2'h0: gate = 1'b1;
      2'h1: gate = ext_clock_input[0];
      2'h2: gate = ext_clock_input[1];
      default: gate = ext_clock_input[2];
    endcase
  end
  wire cnt_edge = sel_lvl && !sel_q && gate;
  // A counting edge moves the counter only while enabled and started
  wire cnt_step = cnt_edge && (running || trig_pend) && clock_enabled_flag;
  // Edge detect on the I/O lines and the waveform event source
  wire a_rise = IO_LINE_A_IN && !line_a_q;
  wire a_fall = !IO_LINE_A_IN && line_a_q;
  reg ev_lvl;
  always @* begin
    if (!wave) ev_lvl = channel_mode_setup[`TCCH_M_ABSEL] ? IO_LINE_A_IN : IO_LINE_B_IN;
    else if (evsrc == 2'h0) ev_lvl = IO_LINE_B_IN;
    else ev_lvl = ext_clock_input[evsrc - 2'h1];
  end
  wire ev_rise = ev_lvl && !ev_q;
  wire ev_fall = !ev_lvl && ev_q;
  // Edge code: 0 none, 1 rising, 2 falling, 3 both
  function edge_hit(input [1:0] sel, input r, input f);
    edge_hit = (sel[0] && r) || (sel[1] && f);
  endfunction
  wire ext_evt = edge_hit(etrg_edge, ev_rise, ev_fall);
  wire ext_trig = ext_evt && (!wave || channel_mode_setup[`TCCH_M_EVTEN]);
  wire c_match = (live_count_value == compare_c) && cnt_step;
  wire c_trig = c_match && channel_mode_setup[`TCCH_M_TRIGGER_ON_C_MATCH]
    && !(wave && shape == 2'h0);
  wire load_a = !wave && edge_hit(lda, a_rise, a_fall) && (!a_loaded || b_loaded);
  wire load_b = !wave && edge_hit(ldb, a_rise, a_fall) && a_loaded && !load_a;
  // Bus write decode
  wire wr_go = have_aw && have_w && !BVALID;
  wire wr_cmd = wr_go && aw_addr == `TCCH_CMD_OFF;
  wire wr_bcr = wr_go && aw_addr == `TCCH_BCR_OFF;
  wire sw_trig = (wr_cmd && w_data[`TCCH_CMD_SOFT_TRIGGER_CMD])
    || (wr_bcr && w_data[`TCCH_BCR_SYNC]);
  wire any_trig = sw_trig || ext_trig || c_trig;
  wire auto_dis = (load_b && channel_mode_setup[`TCCH_M_DISABLE_ON_SECOND_CAPTURE])
    || (wave && c_match && channel_mode_setup[`TCCH_M_CDIS]);
  wire auto_stop = (load_b && channel_mode_setup[`TCCH_M_STOP_ON_SECOND_CAPTURE])
    || (wave && c_match && channel_mode_setup[`TCCH_M_CSTOP]);
  wire rd_go = ARVALID && !RVALID && !ARREADY;
  wire rd_sr = rd_go && ARADDR == `TCCH_SR_OFF;
  wire rd_ra = rd_go && ARADDR == `TCCH_RA_OFF;
  wire rd_rb = rd_go && ARADDR == `TCCH_RB_OFF;
  reg [31:0] rd_val;
  always @* begin
    if (ARADDR == `TCCH_MODE_OFF) rd_val = channel_mode_setup;
    else if (ARADDR == `TCCH_CV_OFF) rd_val = live_count_value;
    else if (ARADDR == `TCCH_RA_OFF) rd_val = capture_compare_a;
    else if (ARADDR == `TCCH_RB_OFF) rd_val = capture_compare_b;
    else if (ARADDR == `TCCH_RC_OFF) rd_val = compare_c;
    else if (ARADDR == `TCCH_SR_OFF)
      rd_val = {15'h0000, clock_enabled_flag, 14'h0000, capture_overrun_flag, counter_wrap_flag};
    else if (ARADDR == `TCCH_BMR_OFF) rd_val = {26'h0000000, block_routing_setup};
    else rd_val = 32'h00000000;
  end
  wire rd_ok = (ARADDR == `TCCH_MODE_OFF) || (ARADDR == `TCCH_CV_OFF)
    || (ARADDR == `TCCH_RA_OFF) || (ARADDR == `TCCH_RB_OFF) || (ARADDR == `TCCH_RC_OFF)
    || (ARADDR == `TCCH_SR_OFF) || (ARADDR == `TCCH_BMR_OFF);
  wire wr_ok = (aw_addr == `TCCH_CMD_OFF) || (aw_addr == `TCCH_MODE_OFF)
    || (aw_addr == `TCCH_RA_OFF) || (aw_addr == `TCCH_RB_OFF) || (aw_addr == `TCCH_RC_OFF)
    || (aw_addr == `TCCH_BCR_OFF) || (aw_addr == `TCCH_BMR_OFF);
  always @(posedge CLOCK) begin
    if (!RSTN) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RRESP <= 2'h0;
      RDATA <= 32'h00000000;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      channel_mode_setup <= 32'h00000000;
      block_routing_setup <= 6'h00;
      live_count_value <= 32'h00000000;
      capture_compare_a <= 32'h00000000;
      capture_compare_b <= 32'h00000000;
      compare_c <= 32'h00000000;
      counter_wrap_flag <= 1'b0;
      capture_overrun_flag <= 1'b0;
      clock_enabled_flag <= 1'b0;
      running <= 1'b0;
      trig_pend <= 1'b0;
      a_loaded <= 1'b0;
      b_loaded <= 1'b0;
      a_unread <= 1'b0;
      b_unread <= 1'b0;
      div_cnt <= 8'h00;
      slow_cnt <= 16'h0000;
      slow_tick <= 1'b0;
      sel_q <= 1'b0;
      line_a_q <= 1'b0;
      line_b_q <= 1'b0;
      ev_q <= 1'b0;
      IO_LINE_A_OUT <= 1'b0;
      IO_LINE_A_OE <= 1'b0;
      IO_LINE_B_OUT <= 1'b0;
      IO_LINE_B_OE <= 1'b0;
      SYNC_OUT <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == `TCCH_DIV_MAX) ? 8'h00 : div_cnt + 8'h01;
      slow_cnt <= (slow_cnt == `TCCH_SLOW_DIV) ? 16'h0000 : slow_cnt + 16'h0001;
      if (slow_cnt == `TCCH_SLOW_DIV) slow_tick <= !slow_tick;
      sel_q <= sel_lvl;
      line_a_q <= IO_LINE_A_IN;
      line_b_q <= IO_LINE_B_IN;
      ev_q <= ev_lvl;
      // Write channel: address and data accepted in either order
      if (AWVALID && !have_aw && !AWREADY) begin
        AWREADY <= 1'b1;
        have_aw <= 1'b1;
        aw_addr <= AWADDR;
      end else AWREADY <= 1'b0;
      if (WVALID && !have_w && !WREADY) begin
        WREADY <= 1'b1;
        have_w <= 1'b1;
        w_data <= WDATA;
      end else WREADY <= 1'b0;
      SYNC_OUT <= wr_bcr && w_data[`TCCH_BCR_SYNC];
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? 2'h0 : 2'h2;
        if (WSTRB == 4'hF || 1'b1) begin
          if (aw_addr == `TCCH_MODE_OFF) channel_mode_setup <= w_data;
          else if (aw_addr == `TCCH_RA_OFF && wave) capture_compare_a <= w_data;
          else if (aw_addr == `TCCH_RB_OFF && wave) capture_compare_b <= w_data;
          else if (aw_addr == `TCCH_RC_OFF) compare_c <= w_data;
          else if (aw_addr == `TCCH_BMR_OFF) block_routing_setup <= w_data[5:0];
        end
      end else if (BVALID && BREADY) BVALID <= 1'b0;
      // Read channel
      if (rd_go) begin
        ARREADY <= 1'b1;
        RVALID <= 1'b1;
        RDATA <= rd_val;
        RRESP <= rd_ok ? 2'h0 : 2'h2;
      end else begin
        ARREADY <= 1'b0;
        if (RVALID && RREADY) RVALID <= 1'b0;
      end
      // Clock enable and start/stop
      if (wr_cmd && w_data[`TCCH_CMD_DIS]) clock_enabled_flag <= 1'b0;
      else if (wr_cmd && w_data[`TCCH_CMD_EN]) clock_enabled_flag <= 1'b1;
      else if (auto_dis) clock_enabled_flag <= 1'b0;
      if (!clock_enabled_flag) running <= 1'b0;
      else if (any_trig) running <= 1'b1;
      else if (auto_stop) running <= 1'b0;
      // Software and external triggers wait for the next counting edge;
      // a C match already sits on such an edge and clears the count there
      if (sw_trig || ext_trig) trig_pend <= 1'b1;
      else if (cnt_edge) trig_pend <= 1'b0;
      if (any_trig) begin
        a_loaded <= 1'b0;
        b_loaded <= 1'b0;
      end
      if (cnt_step) begin
        if (trig_pend || c_trig) live_count_value <= 32'h00000000;
        else live_count_value <= live_count_value + 32'h00000001;
      end
      // Status flags: set wins over read-clear
      if (cnt_step && !trig_pend && !c_trig && live_count_value == 32'hFFFFFFFF)
        counter_wrap_flag <= 1'b1;
      else if (rd_sr) counter_wrap_flag <= 1'b0;
      if ((load_a && a_unread) || (load_b && b_unread)) capture_overrun_flag <= 1'b1;
      else if (rd_sr) capture_overrun_flag <= 1'b0;
      if (load_a) begin
        capture_compare_a <= live_count_value;
        a_loaded <= 1'b1;
        b_loaded <= 1'b0;
        a_unread <= 1'b1;
      end else if (rd_ra) a_unread <= 1'b0;
      if (load_b) begin
        capture_compare_b <= live_count_value;
        b_loaded <= 1'b1;
        a_loaded <= 1'b0;
        b_unread <= 1'b1;
      end else if (rd_rb) b_unread <= 1'b0;
      // Line directions and compare-driven outputs
      IO_LINE_A_OE <= wave;
      IO_LINE_B_OE <= wave && !b_is_event;
      // A frozen count must not keep matching, so compares follow real steps
      if (wave && cnt_step) begin
        if (live_count_value == capture_compare_a) IO_LINE_A_OUT <= 1'b1;
        if (c_match) IO_LINE_A_OUT <= 1'b0;
        if (!b_is_event && live_count_value == capture_compare_b) IO_LINE_B_OUT <= 1'b1;
        if (!b_is_event && c_match) IO_LINE_B_OUT <= 1'b0;
      end
    end
  end
endmodule

// ==== rtl/tcch_map.vh ====
`ifndef TCCH_MAP_VH
`define TCCH_MAP_VH
// Register byte offsets
`define TCCH_CMD_OFF 8'h00
`define TCCH_MODE_OFF 8'h04
`define TCCH_CV_OFF 8'h10
`define TCCH_RA_OFF 8'h14
`define TCCH_RB_OFF 8'h18
`define TCCH_RC_OFF 8'h1C
`define TCCH_SR_OFF 8'h20
`define TCCH_BCR_OFF 8'hC0
`define TCCH_BMR_OFF 8'hC4
// Command bits
`define TCCH_CMD_EN 0
`define TCCH_CMD_DIS 1
`define TCCH_CMD_SOFT_TRIGGER_CMD 2
`define TCCH_BCR_SYNC 0
// Mode field positions
`define TCCH_M_CKS_LO 0
`define TCCH_M_CKS_HI 2
`define TCCH_M_INV 3
`define TCCH_M_BST_LO 4
`define TCCH_M_BST_HI 5
`define TCCH_M_STOP_ON_SECOND_CAPTURE 6
`define TCCH_M_DISABLE_ON_SECOND_CAPTURE 7
`define TCCH_M_ETE_LO 8
`define TCCH_M_ETE_HI 9
`define TCCH_M_ABSEL 10
`define TCCH_M_EVS_LO 10
`define TCCH_M_EVS_HI 11
`define TCCH_M_EVTEN 12
`define TCCH_M_TRIGGER_ON_C_MATCH 14
`define TCCH_M_WAVE 15
`define TCCH_M_LDA_LO 16
`define TCCH_M_LDA_HI 17
`define TCCH_M_LDB_LO 18
`define TCCH_M_LDB_HI 19
`define TCCH_M_CSTOP 20
`define TCCH_M_CDIS 21
`define TCCH_M_SHP_LO 22
`define TCCH_M_SHP_HI 23
// Status bits
`define TCCH_SR_COVF 0
`define TCCH_SR_LOVR 1
`define TCCH_SR_CLOCK_ENABLED_FLAG 16
// Divider ratios
`define TCCH_DIV_MAX 8'h7F
`define TCCH_SLOW_DIV 16'h05F5
`endif

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "tcch_map.vh"
module tb;
  logic CLOCK = 1'b0, RSTN = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0, ext_run = 1'b0, pulse_a = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, rdat, v;
  logic [1:0] rrsp, brsp;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, SYNC_OUT, fa, fb;
  wire IO_LINE_A_IN, IO_LINE_B_IN, IO_LINE_A_OUT, IO_LINE_A_OE, IO_LINE_B_OUT, IO_LINE_B_OE;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [2:0] EXT_CLOCK_PIN;
  wire [3:0] WSTRB = 4'hF;
  wire [1:0] CHAIN_LINE_A = 2'h0;
  integer fail_count = 0, n_checks = 0, nsync = 0;
  // Wire level: the channel wins while it drives
  assign IO_LINE_A_IN = IO_LINE_A_OE ? IO_LINE_A_OUT : fa;
  assign IO_LINE_B_IN = IO_LINE_B_OE ? IO_LINE_B_OUT : fb;
  tcch_core u_dut (.*);
  tcch_far u_far (.CLOCK(CLOCK), .ext_run(ext_run), .pulse_a(pulse_a),
    .ext_pin(EXT_CLOCK_PIN), .line_a(fa), .line_b(fb));
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (SYNC_OUT === 1'b1) nsync <= nsync + 1;
  end
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      fail_count = fail_count + 1;
      $display("ERROR handshake expected 1 seen 0");
      results;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    integer i;
    logic pa, pw;
    begin
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      for (i = 0; i < 20 && (pa || pw); i++) begin
        @(posedge CLOCK);
        if (AWREADY === 1'b1) begin
          AWVALID <= 1'b0;
          pa = 1'b0;
        end
        if (WREADY === 1'b1) begin
          WVALID <= 1'b0;
          pw = 1'b0;
        end
      end
      if (pa || pw) tmo;
      repeat (2) @(posedge CLOCK);
      BREADY <= 1'b1;
      for (i = 0; i < 20 && !pa; i++) begin
        @(posedge CLOCK);
        if (BVALID === 1'b1) begin
          pa = 1'b1;
          brsp = BRESP;
        end
      end
      BREADY <= 1'b0;
      if (!pa) tmo;
    end
  endtask
  task rd(input logic [7:0] a);
    integer i;
    logic p;
    begin
      ARADDR <= a;
      ARVALID <= 1'b1;
      p = 1'b1;
      for (i = 0; i < 20 && p; i++) begin
        @(posedge CLOCK);
        if (ARREADY === 1'b1) p = 1'b0;
      end
      ARVALID <= 1'b0;
      RREADY <= 1'b1;
      if (p) tmo;
      for (i = 0; i < 20 && !p; i++) begin
        @(posedge CLOCK);
        if (RVALID === 1'b1) p = 1'b1;
      end
      rdat = RDATA;
      rrsp = RRESP;
      RREADY <= 1'b0;
      if (!p) tmo;
    end
  endtask
  task wa(input logic val);
    integer i;
    begin
      for (i = 0; i < 400 && IO_LINE_A_OUT !== val; i++) @(posedge CLOCK);
      chk("line a", {31'h0, val}, {31'h0, IO_LINE_A_OUT});
      if (IO_LINE_A_OUT !== val) results;
    end
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    rd(`TCCH_CV_OFF); chk("count", 32'h0, rdat);
    rd(8'h0C); chk("resp", 32'h2, rrsp);
    wr(`TCCH_CMD_OFF, 32'h1);
    wr(`TCCH_CMD_OFF, 32'h4);
    rd(`TCCH_SR_OFF); chk("clock on", 32'h1, rdat[16]);
    repeat (40) @(posedge CLOCK);
    rd(`TCCH_CV_OFF); v = rdat;
    rd(`TCCH_CV_OFF); chk("counting", 32'h1, rdat > v);
    wr(`TCCH_BCR_OFF, 32'h1);
    chk("sync", 32'h1, nsync);
    chk("write resp", 32'h0, brsp);
    rd(`TCCH_CV_OFF); chk("sync reset", 32'h1, rdat < v);
    wr(`TCCH_CMD_OFF, 32'h2);
    rd(`TCCH_CV_OFF); v = rdat;
    wr(`TCCH_CMD_OFF, 32'h4);
    rd(`TCCH_CV_OFF); chk("held", v, rdat);
    rd(`TCCH_SR_OFF); chk("clock off", 32'h0, rdat[16]);
    wr(`TCCH_MODE_OFF, 32'h0000_8000);
    wr(`TCCH_RA_OFF, 32'h14);
    wr(`TCCH_RC_OFF, 32'h3C);
    chk("a drive", 32'h1, IO_LINE_A_OE);
    chk("b drive", 32'h0, IO_LINE_B_OE);
    wr(`TCCH_MODE_OFF, 32'h0000_8400);
    rd(`TCCH_RA_OFF); chk("reg a", 32'h14, rdat);
    chk("b drive", 32'h1, IO_LINE_B_OE);
    wr(`TCCH_CMD_OFF, 32'h1);
    wr(`TCCH_CMD_OFF, 32'h4);
    wa(1'b1);
    chk("line b", 32'h1, IO_LINE_B_OUT);
    wa(1'b0);
    chk("line b low", 32'h0, IO_LINE_B_OUT);
    rd(`TCCH_CV_OFF); chk("free run", 32'h1, rdat > 32'h3C);
    wr(`TCCH_MODE_OFF, 32'h0020_8400);
    wr(`TCCH_CMD_OFF, 32'h4);
    wa(1'b1);
    wa(1'b0);
    rd(`TCCH_SR_OFF); chk("c disable", 32'h0, rdat[16]);
    wr(`TCCH_MODE_OFF, 32'h0009_0000);
    wr(`TCCH_CMD_OFF, 32'h1);
    wr(`TCCH_CMD_OFF, 32'h4);
    repeat (2) begin
      pulse_a <= 1'b1;
      repeat (10) @(posedge CLOCK);
      pulse_a <= 1'b0;
      repeat (10) @(posedge CLOCK);
    end
    rd(`TCCH_SR_OFF); chk("overrun", 32'h1, rdat[1]);
    rd(`TCCH_SR_OFF); chk("overrun clear", 32'h0, rdat[1]);
    rd(`TCCH_RA_OFF); v = rdat;
    rd(`TCCH_RB_OFF); chk("width", 32'h5, rdat - v);
    wr(`TCCH_MODE_OFF, 32'h5);
    wr(`TCCH_CMD_OFF, 32'h1);
    wr(`TCCH_CMD_OFF, 32'h4);
    ext_run <= 1'b1;
    repeat (160) @(posedge CLOCK);
    ext_run <= 1'b0;
    rd(`TCCH_CV_OFF); chk("ext count", 32'h1, rdat == 32'h13 || rdat == 32'h14);
    wr(`TCCH_MODE_OFF, 32'h0000_4000);
    wr(`TCCH_CMD_OFF, 32'h4);
    repeat (300) @(posedge CLOCK);
    rd(`TCCH_CV_OFF); chk("c trigger", 32'h1, rdat <= 32'h3C);
    results;
  end
  initial begin
    #1000000;
    tmo;
  end
endmodule

// ==== tb/tcch_chk_assertions.sv ====
`timescale 1ns/1ps
module tcch_chk (
  // Clock and reset
  input wire CLOCK,
  input wire RSTN,
  // Bus handshakes
  input wire AWVALID,
  input wire AWREADY,
  input wire WVALID,
  input wire WREADY,
  input wire BVALID,
  input wire BREADY,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [1:0] RRESP,
  input wire [31:0] RDATA,
  // Lines and sync
  input wire SYNC_OUT,
  input wire IO_LINE_A_OE,
  input wire IO_LINE_B_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_take;
    AWREADY && WREADY;
  endsequence
  sequence s_answer;
    s_take ##1 BVALID;
  endsequence
  a_write_answer: assert property ($rose(AWVALID) && WVALID |=> s_answer)
    else $error("write not answered");
  a_bvalid_holds: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  a_read_answer: assert property ($rose(ARVALID) |=> ARREADY && RVALID)
    else $error("read not answered");
  a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  a_aready_pulse: assert property (AWREADY |=> !AWREADY)
    else $error("address ready too long");
  a_resp_code: assert property (RVALID |-> !RRESP[0])
    else $error("bad read response code");
  a_sync_pulse: assert property (SYNC_OUT |=> !SYNC_OUT)
    else $error("sync pulse too long");
  a_line_b_drive: assert property (IO_LINE_B_OE |-> IO_LINE_A_OE)
    else $error("line b driven without line a");
endmodule
bind tcch_core tcch_chk u_chk (.*);

// ==== tb/tcch_far.sv ====
`timescale 1ns/1ps
module tcch_far (
  // Clock and bench controls
  input wire CLOCK,
  input wire ext_run,
  input wire pulse_a,
  // Lines toward the channel
  output reg [2:0] ext_pin = 3'h0,
  output reg line_a = 1'b0,
  output reg line_b = 1'b0
);
  reg [1:0] div = 2'h0;
  // Slow external clock, each level four cycles, low while idle
  always @(posedge CLOCK) begin
    div <= ext_run ? div + 2'h1 : 2'h0;
    if (!ext_run)
      ext_pin[0] <= 1'b0;
    else if (div == 2'h3)
      ext_pin[0] <= ~ext_pin[0];
    line_a <= pulse_a;
    line_b <= ~line_b;
  end
endmodule
